// ---- core/lws_pkg.sv ----
// package for the late-write synchronous sram core
package lws_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 36;
  typedef struct packed {
    logic              sel_n;
    logic              sync_write_strobe_n;
    logic [ADDR_W-1:0] word_address_bus;
  } lws_cmd_t;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
endpackage

// ---- core/lws_core.sv ----
// late-write synchronous sram datapath with one-entry write buffer
`timescale 1ns/1ns
`default_nettype none
module lws_core
#(
  parameter int unsigned DEPTH = 1 << lws_pkg::ADDR_W
)
(
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  input  wire lws_pkg::lws_cmd_t         cmd_i,
  input  wire logic [lws_pkg::DATA_W-1:0] data_io_bus_i,
  output var  logic [lws_pkg::DATA_W-1:0] data_io_bus_o,
  output var  logic                      data_io_bus_oe_o
);
  import lws_pkg::*;

  // array index width; upper address bits are ignored when DEPTH is reduced
  localparam int unsigned IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // idle command held in the synchronisers while in reset
  localparam lws_cmd_t CMD_IDLE = '{
    sel_n:               1'b1,
    sync_write_strobe_n: 1'b1,
    word_address_bus:    ADDR_RST
  };

  ////////////////////////////////////////////////////////////////////////////
  // command decode and array index helpers
  function automatic logic cmd_is
  (
    input lws_cmd_t c,
    input logic     want_write
  );
    cmd_is = !c.sel_n && (c.sync_write_strobe_n == !want_write);
  endfunction

  function automatic logic [IDX_W-1:0] arr_idx
  (
    input logic [ADDR_W-1:0] a
  );
    arr_idx = a[IDX_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  lws_cmd_t          cmd_s1;
  lws_cmd_t          cmd;
  logic [DATA_W-1:0] din_s1;
  logic [DATA_W-1:0] din;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cmd_s1 <= CMD_IDLE;
      cmd    <= CMD_IDLE;
    end
    else
    begin
      cmd_s1 <= cmd_i;
      cmd    <= cmd_s1;
    end
  end

  // data pins take the same two stages, so a write keeps its one-cycle data offset
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      din_s1 <= DATA_RST;
      din    <= DATA_RST;
    end
    else
    begin
      din_s1 <= data_io_bus_i;
      din    <= din_s1;
    end
  end

  // decoded after synchronisation; a high select is an idle cycle
  wire logic rd_req = cmd_is(cmd, 1'b0);
  wire logic wr_req = cmd_is(cmd, 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // address register and write-data phase
  // registered every cycle; rd_q and wr_q say which phase the address belongs to
  logic [ADDR_W-1:0] addr_q;
  logic              rd_q;
  logic              wr_q;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      addr_q <= ADDR_RST;
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
    end
    else
    begin
      addr_q <= cmd.word_address_bus;
      rd_q   <= rd_req;
      wr_q   <= wr_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-entry write buffer
  // loads only in a write data phase and empties only through reset
  logic [ADDR_W-1:0] buf_addr;
  logic [DATA_W-1:0] buf_data;
  logic              buf_full;
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      buf_addr <= ADDR_RST;
      buf_data <= DATA_RST;
      buf_full <= 1'b0;
    end
    else if (wr_q)
    begin
      buf_addr <= addr_q;
      buf_data <= din;
      buf_full <= 1'b1;
    end
  end

  // commit the older pending write when the next write's data phase loads
  always_ff @(posedge clk_i)
  begin
    if (wr_q && buf_full)
    begin
      mem[arr_idx(buf_addr)] <= buf_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path with bypass from the buffer
  wire logic hit = buf_full && (buf_addr == addr_q);
  // array word at the registered address, used when the buffer does not match
  wire logic [DATA_W-1:0] arr_word = mem[arr_idx(addr_q)];

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_io_bus_oe_o <= 1'b0;
    end
    else
    begin
      data_io_bus_oe_o <= rd_q;
    end
  end

  // read data stands until the next read replaces it or reset clears it to DATA_RST
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_io_bus_o <= DATA_RST;
    end
    else if (rd_q)
    begin
      data_io_bus_o <= hit ? buf_data : arr_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_read_one_cycle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_q |=> data_io_bus_oe_o)
    else $error("read data not driven one cycle after address");
  a_no_stray_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !rd_q |=> !data_io_bus_oe_o)
    else $error("output driven without read");
  a_bypass_data: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rd_q && hit) |=> data_io_bus_o == $past(buf_data))
    else $error("bypass did not forward buffer data");
  a_write_capture: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_req |=> ##1 (buf_full && buf_data == $past(din)))
    else $error("write data not captured in data phase");
  a_buf_addr_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_q |=> buf_addr == $past(addr_q))
    else $error("buffer address not loaded");
  a_empty_after_reset: assert property (@(posedge clk_i)
    $rose(rstn_i) |-> !buf_full)
    else $error("buffer not empty after reset");
  a_full_stays: assert property (@(posedge clk_i) disable iff (!rstn_i)
    buf_full |=> buf_full)
    else $error("pending write lost");
  a_addr_reg: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_req |=> addr_q == $past(cmd.word_address_bus))
    else $error("read address not registered");
  // read miss data, buffer and output behaviour between accesses, selected command through the synchroniser
  a_miss_from_array: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rd_q && !hit) |=> data_io_bus_o == $past(arr_word))
    else $error("read miss did not return array word");
  a_hold_no_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !rd_q |=> $stable(data_io_bus_o))
    else $error("read data changed without read");
  a_write_no_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_q |=> !data_io_bus_oe_o)
    else $error("write data phase drove read data");
  a_buffer_stable: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !wr_q |=> ($stable(buf_addr) && $stable(buf_data)))
    else $error("write buffer changed outside data phase");
  a_empty_until_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!buf_full && !wr_q) |=> !buf_full)
    else $error("buffer filled without write");
  a_sync_pass: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !cmd_s1.sel_n |=> cmd == $past(cmd_s1))
    else $error("selected command altered in synchroniser");

  // main scenarios
  c_read_hit: cover property (@(posedge clk_i) disable iff (!rstn_i) rd_q && hit);
  c_read_miss: cover property (@(posedge clk_i) disable iff (!rstn_i) rd_q && !hit);
  c_commit: cover property (@(posedge clk_i) disable iff (!rstn_i) wr_q && buf_full);
  c_write_pair: cover property (@(posedge clk_i) disable iff (!rstn_i) wr_q ##1 wr_q);
  c_read_after_write: cover property (@(posedge clk_i) disable iff (!rstn_i) wr_q ##1 rd_q);
endmodule
`default_nettype wire

// ---- verification/lws_ctl_model.sv ----
// controller model driving commands and late write data
`timescale 1ns/1ns
`default_nettype none
module lws_ctl_model
(
  input  wire logic                       clk_i,
  output var  lws_pkg::lws_cmd_t          cmd_o,
  output var  logic [lws_pkg::DATA_W-1:0] data_o
);
  import lws_pkg::*;
  logic              pend_wr = 1'b0;
  logic [DATA_W-1:0] pend_d;
  initial cmd_o = {1'b1, 1'b1, ADDR_RST};
  initial data_o = DATA_RST;
  // data of a write follows one cycle later, else the bus toggles
  task automatic op(input logic s, input logic w, input logic [19:0] a, input logic [35:0] d);
    @(posedge clk_i);
    #1;
    data_o = pend_wr ? pend_d : ~data_o;
    cmd_o = {~s, ~w, a};
    pend_wr = s & w;
    pend_d = d;
  endtask
endmodule
`default_nettype wire

// ---- verification/test_late_write_sync_sram_core.sv ----
// testbench for the late-write sram core
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t bad", $time); end end
module test_late_write_sync_sram_core;
  import lws_pkg::*;
  logic              clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  lws_cmd_t          cmd;
  logic [DATA_W-1:0] wdat;
  logic [DATA_W-1:0] rdat;
  logic              oe;
  int                errors = 0;
  int                n_compared = 0;
  initial forever #4 clk_i = ~clk_i;
  lws_ctl_model u_lws_ctl_model (.clk_i(clk_i), .cmd_o(cmd), .data_o(wdat));
  lws_core #(.DEPTH(1024)) u_lws_core (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_i(cmd),
    .data_io_bus_i(wdat), .data_io_bus_o(rdat), .data_io_bus_oe_o(oe));
  task automatic wr(input logic [19:0] a, input logic [35:0] d);
    u_lws_ctl_model.op(1'b1, 1'b1, a, d);
  endtask
  task automatic rd(input logic [19:0] a, input logic [35:0] e);
    u_lws_ctl_model.op(1'b1, 1'b0, a, 36'h0);
    repeat (3) u_lws_ctl_model.op(1'b0, 1'b0, a, 36'h0);
    `CHK(oe, 1'b0)
    @(posedge clk_i);
    #1;
    `CHK(oe, 1'b1)
    `CHK(rdat, e)
  endtask
  task automatic t_reset;
    `CHK(oe, 1'b0)
    `CHK(rdat, DATA_RST)
  endtask
  task automatic t_bypass;
    wr(20'h3, 36'h1_2345_6789);
    rd(20'h3, 36'h1_2345_6789);
    wr(20'h3, 36'hA_BCDE_F012);
    rd(20'h3, 36'hA_BCDE_F012);
  endtask
  task automatic t_commit;
    wr(20'h7, 36'h5_5555_AAAA);
    rd(20'h3, 36'hA_BCDE_F012);
    rd(20'h7, 36'h5_5555_AAAA);
  endtask
  task automatic t_idle;
    u_lws_ctl_model.op(1'b0, 1'b1, 20'h7, 36'hF_0F0F_0F0F);
    rd(20'h7, 36'h5_5555_AAAA);
  endtask
  task automatic t_reset_mid;
    wr(20'h5, 36'h1_1111_1111);
    wr(20'h9, 36'h2_2222_2222);
    wr(20'h5, 36'h3_3333_3333);
    rd(20'h5, 36'h3_3333_3333);
    rstn_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(oe, 1'b0)
    `CHK(rdat, DATA_RST)
    rstn_i = 1'b1;
    rd(20'h5, 36'h1_1111_1111);
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #20000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    t_reset();
    rstn_i = 1'b1;
    t_bypass();
    t_commit();
    t_idle();
    t_reset_mid();
    tally_and_finish();
  end
endmodule
`default_nettype wire
